// >>> verilog/ipv4_match_pkg.sv
// Behaviour
// - ipv4 comparisons count only when the entry frame type is ipv4
// - protocol selection any: protocol field is don't-care
// - protocol selection specific: protocol field must equal the 8-bit configured value
// - protocol selection icmp: only icmp frames match, icmp sub-criteria enabled
// - protocol selection udp: only udp frames match, udp port sub-criteria enabled
// - protocol selection tcp: only tcp frames match, tcp port sub-criteria enabled
// - ttl setting zero: frames with ttl above zero never match
// - ttl setting non-zero: ttl above zero may match; any ignores ttl
// - fragment setting no: more-fragments set or nonzero offset never matches
// - fragment setting yes: fragmented frames may match; any ignores both fields
// - option setting no: frames with options present never match
// - option setting yes: frames with options may match; any ignores options
// - source filter any: source address is don't-care
// - source filter host: full 32-bit source address must equal configured one
// - source filter network: source compared only where source mask bits are set
// - destination filter any: destination address is don't-care
// - destination filter host: full destination address must equal configured one
// - destination filter network: compared only where destination mask bits are set
package ipv4_match_pkg;

    // register byte offsets
    localparam logic [4:0] control_offset = 5'h00;
    localparam logic [4:0] source_ip_filter_addr_offset = 5'h04;
    localparam logic [4:0] source_ip_filter_mask_offset = 5'h08;
    localparam logic [4:0] destination_ip_filter_addr_offset = 5'h0c;
    localparam logic [4:0] destination_ip_filter_mask_offset = 5'h10;
    localparam logic [4:0] status_offset = 5'h14;

    // control register fields
    localparam int ctl_ipv4_bit = 0;
    localparam int ctl_proto_lsb = 1;
    localparam int ctl_ttl_lsb = 4;
    localparam int ctl_frag_lsb = 6;
    localparam int ctl_opt_lsb = 8;
    localparam int ctl_src_lsb = 10;
    localparam int ctl_dst_lsb = 12;
    localparam int ctl_value_lsb = 16;
    localparam logic [31:0] control_reset = 32'h0000_0000;
    localparam logic [31:0] addr_reset = 32'h0000_0000;
    localparam logic [31:0] mask_reset = 32'hffff_ffff;

    // status register fields
    localparam int st_hit_bit = 0;
    localparam int st_seen_bit = 1;
    localparam int st_count_lsb = 16;

    // protocol selection codes
    localparam logic [2:0] proto_any = 3'h0;
    localparam logic [2:0] proto_specific = 3'h1;
    localparam logic [2:0] proto_icmp = 3'h2;
    localparam logic [2:0] proto_udp = 3'h3;
    localparam logic [2:0] proto_tcp = 3'h4;

    // tri-state condition codes (ttl, fragment, option)
    localparam logic [1:0] cond_any = 2'h0;
    localparam logic [1:0] cond_no = 2'h1;
    localparam logic [1:0] cond_yes = 2'h2;

    // address filter codes
    localparam logic [1:0] addr_any = 2'h0;
    localparam logic [1:0] addr_host = 2'h1;
    localparam logic [1:0] addr_network = 2'h2;

    // ipv4 protocol numbers
    localparam logic [7:0] ip_proto_icmp = 8'h01;
    localparam logic [7:0] ip_proto_tcp = 8'h06;
    localparam logic [7:0] ip_proto_udp = 8'h11;

    typedef struct packed {
        logic is_ipv4;
        logic [7:0] protocol;
        logic [7:0] ttl;
        logic more_fragments_bit;
        logic [12:0] fragment_position_field;
        logic options_present;
        logic [31:0] src_addr;
        logic [31:0] dst_addr;
    } frame_fields_type;

    typedef struct packed {
        logic icmp_en;
        logic udp_port_en;
        logic tcp_port_en;
    } sub_enable_type;

endpackage

// >>> verilog/ipv4_ace_field_matcher.sv
`timescale 1ns/100ps
module ipv4_ace_field_matcher
    import ipv4_match_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // avalon-mm slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // parsed frame from ingress parser
    input wire logic frame_valid,
    input wire frame_fields_type frame_fields,
    // match result
    output logic hit_valid_q,
    output logic hit_q,
    output sub_enable_type sub_enable_q
);

    logic [31:0] control_q;
    logic [31:0] src_addr_q;
    logic [31:0] src_mask_q;
    logic [31:0] dst_addr_q;
    logic [31:0] dst_mask_q;
    logic ack_q;
    logic [31:0] readdata_q;
    logic [15:0] hit_count_q;
    logic seen_q;

    logic entry_ipv4;
    logic [2:0] proto_sel;
    logic [1:0] ttl_sel;
    logic [1:0] frag_sel;
    logic [1:0] opt_sel;
    logic [1:0] src_sel;
    logic [1:0] dst_sel;
    logic [7:0] proto_value;

    assign entry_ipv4 = control_q[ctl_ipv4_bit];
    assign proto_sel = control_q[ctl_proto_lsb +: 3];
    assign ttl_sel = control_q[ctl_ttl_lsb +: 2];
    assign frag_sel = control_q[ctl_frag_lsb +: 2];
    assign opt_sel = control_q[ctl_opt_lsb +: 2];
    assign src_sel = control_q[ctl_src_lsb +: 2];
    assign dst_sel = control_q[ctl_dst_lsb +: 2];
    assign proto_value = control_q[ctl_value_lsb +: 8];

    // bus: every access takes exactly one wait cycle
    logic request;
    logic write_taken;
    assign request = avs_read | avs_write;
    assign avs_waitrequest = ~ack_q;
    assign write_taken = avs_write & ack_q;
    assign avs_readdata = readdata_q;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= request & ~ack_q;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            readdata_q <= 32'h0000_0000;
        end else if (avs_read & ~ack_q) begin
            if (avs_address == control_offset) begin
                readdata_q <= control_q;
            end else if (avs_address == source_ip_filter_addr_offset) begin
                readdata_q <= src_addr_q;
            end else if (avs_address == source_ip_filter_mask_offset) begin
                readdata_q <= src_mask_q;
            end else if (avs_address == destination_ip_filter_addr_offset) begin
                readdata_q <= dst_addr_q;
            end else if (avs_address == destination_ip_filter_mask_offset) begin
                readdata_q <= dst_mask_q;
            end else if (avs_address == status_offset) begin
                readdata_q <= {hit_count_q, 14'h0000, seen_q, hit_q};
            end else begin
                readdata_q <= 32'h0000_0000;
            end
        end
    end

    // unused control bits are kept zero so they read back as zero
    localparam logic [31:0] control_used = 32'h00ff_3fff;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            control_q <= control_reset;
            src_addr_q <= addr_reset;
            src_mask_q <= mask_reset;
            dst_addr_q <= addr_reset;
            dst_mask_q <= mask_reset;
        end else if (write_taken) begin
            if (avs_address == control_offset) begin
                control_q <= avs_writedata & control_used;
            end else if (avs_address == source_ip_filter_addr_offset) begin
                src_addr_q <= avs_writedata;
            end else if (avs_address == source_ip_filter_mask_offset) begin
                src_mask_q <= avs_writedata;
            end else if (avs_address == destination_ip_filter_addr_offset) begin
                dst_addr_q <= avs_writedata;
            end else if (avs_address == destination_ip_filter_mask_offset) begin
                dst_mask_q <= avs_writedata;
            end
        end
    end

    // criteria
    logic proto_ok;
    logic ttl_ok;
    logic frag_ok;
    logic opt_ok;
    logic src_ok;
    logic dst_ok;
    logic frag_present;
    logic ttl_above_zero;
    logic ipv4_part_hit;

    assign frag_present = frame_fields.more_fragments_bit | (frame_fields.fragment_position_field != 13'h0000);
    assign ttl_above_zero = frame_fields.ttl != 8'h00;

    always_comb begin
        case (proto_sel)
            proto_any: proto_ok = 1'b1;
            proto_specific: proto_ok = frame_fields.protocol == proto_value;
            proto_icmp: proto_ok = frame_fields.protocol == ip_proto_icmp;
            proto_udp: proto_ok = frame_fields.protocol == ip_proto_udp;
            proto_tcp: proto_ok = frame_fields.protocol == ip_proto_tcp;
            default: proto_ok = 1'b0;
        endcase
    end

    // non-zero setting also excludes ttl of zero: the mirror of the zero case
    always_comb begin
        case (ttl_sel)
            cond_no: ttl_ok = ~ttl_above_zero;
            cond_yes: ttl_ok = ttl_above_zero;
            default: ttl_ok = 1'b1;
        endcase
    end

    always_comb begin
        case (frag_sel)
            cond_no: frag_ok = ~frag_present;
            cond_yes: frag_ok = frag_present;
            default: frag_ok = 1'b1;
        endcase
    end

    always_comb begin
        case (opt_sel)
            cond_no: opt_ok = ~frame_fields.options_present;
            cond_yes: opt_ok = frame_fields.options_present;
            default: opt_ok = 1'b1;
        endcase
    end

    always_comb begin
        case (src_sel)
            addr_any: src_ok = 1'b1;
            addr_host: src_ok = frame_fields.src_addr == src_addr_q;
            addr_network: src_ok = ((frame_fields.src_addr ^ src_addr_q) & src_mask_q) == 32'h0000_0000;
            default: src_ok = 1'b0;
        endcase
    end

    always_comb begin
        case (dst_sel)
            addr_any: dst_ok = 1'b1;
            addr_host: dst_ok = frame_fields.dst_addr == dst_addr_q;
            addr_network: dst_ok = ((frame_fields.dst_addr ^ dst_addr_q) & dst_mask_q) == 32'h0000_0000;
            default: dst_ok = 1'b0;
        endcase
    end

    // entry not of ipv4 type: this part does not veto the entry
    always_comb begin
        if (!entry_ipv4) begin
            ipv4_part_hit = 1'b1;
        end else begin
            ipv4_part_hit = frame_fields.is_ipv4 & proto_ok & ttl_ok & frag_ok & opt_ok & src_ok & dst_ok;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            hit_valid_q <= 1'b0;
            hit_q <= 1'b0;
        end else begin
            hit_valid_q <= frame_valid;
            if (frame_valid) begin
                hit_q <= ipv4_part_hit;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            seen_q <= 1'b0;
            hit_count_q <= 16'h0000;
        end else if (frame_valid) begin
            seen_q <= 1'b1;
            // saturate rather than wrap so a busy port never looks idle
            if (ipv4_part_hit && hit_count_q != 16'hffff) begin
                hit_count_q <= hit_count_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sub_enable_q <= '0;
        end else begin
            sub_enable_q.icmp_en <= entry_ipv4 & (proto_sel == proto_icmp);
            sub_enable_q.udp_port_en <= entry_ipv4 & (proto_sel == proto_udp);
            sub_enable_q.tcp_port_en <= entry_ipv4 & (proto_sel == proto_tcp);
        end
    end

endmodule // ipv4_ace_field_matcher

// >>> test/frame_parser_model.sv
`timescale 1ns/100ps
module frame_parser_model
    import ipv4_match_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // request from bench
    input wire logic send_valid,
    input wire frame_fields_type send_fields,
    // parsed frame
    output logic frame_valid,
    output frame_fields_type frame_fields
);
    // fields are not held outside the pulse: inverted so stale values cannot pass
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            frame_valid <= 1'h0;
            frame_fields <= '0;
        end else begin
            frame_valid <= send_valid;
            frame_fields <= send_valid ? send_fields : ~frame_fields;
        end
    end
endmodule // frame_parser_model

// >>> test/ipv4_match_properties.sv
`timescale 1ns/100ps
module ipv4_match_checker
    import ipv4_match_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // register bus
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // frame and result
    input wire logic frame_valid,
    input wire frame_fields_type frame_fields,
    input wire logic hit_valid_q,
    input wire logic hit_q,
    input wire sub_enable_type sub_enable_q
);
    logic [31:0] ctl_q;
    wire logic on = ctl_q[ctl_ipv4_bit] && frame_valid && frame_fields.is_ipv4;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // shadow of control, taken at the edge the write is accepted
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ctl_q <= 32'h0;
        end else if (avs_write && !avs_waitrequest && avs_address == control_offset) begin
            ctl_q <= avs_writedata;
        end
    end
    sequence s_ack;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    property p_ack;
        (avs_read || avs_write) && avs_waitrequest |=> s_ack;
    endproperty
    a_ack: assert property (p_ack) else $error("bus answer not one cycle");
    property p_lat;
        frame_valid |=> hit_valid_q;
    endproperty
    a_lat: assert property (p_lat) else $error("result not one cycle after frame");
    property p_idle;
        !frame_valid |=> !hit_valid_q && $stable(hit_q);
    endproperty
    a_idle: assert property (p_idle) else $error("result moved without frame");
    property p_pass;
        frame_valid && !ctl_q[ctl_ipv4_bit] |=> hit_q;
    endproperty
    a_pass: assert property (p_pass) else $error("non ipv4 entry vetoed frame");
    property p_ttl;
        on && ctl_q[5:4] == cond_no && frame_fields.ttl != 8'h0 |=> !hit_q;
    endproperty
    a_ttl: assert property (p_ttl) else $error("ttl zero setting matched");
    property p_frag;
        on && ctl_q[7:6] == cond_no && (frame_fields.more_fragments_bit
            || frame_fields.fragment_position_field != 13'h0) |=> !hit_q;
    endproperty
    a_frag: assert property (p_frag) else $error("fragment matched");
    property p_opt;
        on && ctl_q[9:8] == cond_no && frame_fields.options_present |=> !hit_q;
    endproperty
    a_opt: assert property (p_opt) else $error("options matched");
    property p_tcp;
        on && ctl_q[3:1] == proto_tcp && frame_fields.protocol != ip_proto_tcp |=> !hit_q;
    endproperty
    a_tcp: assert property (p_tcp) else $error("non tcp frame matched");
    property p_sub;
        ctl_q[ctl_ipv4_bit] && ctl_q[3:1] == proto_udp |=> sub_enable_q == 3'h2;
    endproperty
    a_sub: assert property (p_sub) else $error("udp sub enable wrong");
endmodule // ipv4_match_checker
bind ipv4_ace_field_matcher ipv4_match_checker u_chk (.clk_sys(clk_sys), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .frame_valid(frame_valid),
    .frame_fields(frame_fields), .hit_valid_q(hit_valid_q), .hit_q(hit_q), .sub_enable_q(sub_enable_q));

// >>> test/testbench.sv
`timescale 1ns/100ps
module testbench;
    import ipv4_match_pkg::*;
    logic clk_sys = 1'h0, reset = 1'h1, avs_read = 1'h0, avs_write = 1'h0, send_valid = 1'h0;
    logic [4:0] avs_address = 5'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic avs_waitrequest, frame_valid, hit_valid_q, hit_q;
    frame_fields_type send_fields = '0, frame_fields;
    sub_enable_type sub_enable_q;
    int num_errors = 0, checks = 0, cycles = 0;
    ipv4_ace_field_matcher dut (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .frame_valid(frame_valid), .frame_fields(frame_fields),
        .hit_valid_q(hit_valid_q), .hit_q(hit_q), .sub_enable_q(sub_enable_q));
    frame_parser_model parser (.clk_sys(clk_sys), .reset(reset), .send_valid(send_valid),
        .send_fields(send_fields), .frame_valid(frame_valid), .frame_fields(frame_fields));
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    task final_report;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            final_report();
        end
    end
    task cmp_word(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task cmp_bit(input logic g, input logic e);
        cmp_word({31'h0, g}, {31'h0, e});
    endtask
    // one access; the extra edge keeps back to back calls from redriving in one step
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] w);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= w;
        if (wr) avs_write <= 1'h1;
        else avs_read <= 1'h1;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'h0 && ++n < 50);
        // a slave that never answers ends the run as a failure
        if (avs_waitrequest !== 1'h0) begin
            $display("mismatch at %0t: bus answer never came", $time);
            num_errors++;
            final_report();
        end
        rd = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
        @(posedge clk_sys);
    endtask
    task chk(input logic [31:0] c, input logic e, input logic [7:0] pr = 8'h06, input logic [7:0] tt = 8'h40,
        input logic mf = 1'h0, input logic [12:0] of = 13'h0, input logic op = 1'h0,
        input logic [31:0] s = 32'h0a00_0001, input logic [31:0] d = 32'hc0a8_0101, input logic v4 = 1'h1);
        int n;
        bus(1'h1, control_offset, c);
        send_fields <= {v4, pr, tt, mf, of, op, s, d};
        send_valid <= 1'h1;
        @(posedge clk_sys);
        send_valid <= 1'h0;
        n = 0;
        do @(posedge clk_sys); while (hit_valid_q !== 1'h1 && ++n < 20);
        cmp_bit(hit_valid_q, 1'h1);
        cmp_bit(hit_q, e);
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        reset <= 1'h0;
        @(posedge clk_sys);
        bus(1'h0, control_offset, 32'h0);
        cmp_word(rd, control_reset);
        bus(1'h0, source_ip_filter_mask_offset, 32'h0);
        cmp_word(rd, mask_reset);
        bus(1'h1, status_offset, 32'hffff_ffff);
        bus(1'h0, status_offset, 32'h0);
        cmp_word(rd, 32'h0);
        bus(1'h1, 5'h18, 32'h1234_5678);
        bus(1'h0, 5'h18, 32'h0);
        cmp_word(rd, 32'h0);
        bus(1'h1, source_ip_filter_addr_offset, 32'h0a00_0001);
        bus(1'h1, source_ip_filter_mask_offset, 32'hffff_ff00);
        bus(1'h1, destination_ip_filter_addr_offset, 32'hc0a8_0101);
        bus(1'h1, destination_ip_filter_mask_offset, 32'hffff_0000);
        bus(1'h0, destination_ip_filter_mask_offset, 32'h0);
        cmp_word(rd, 32'hffff_0000);
        chk(32'h0, 1'h1, .v4(1'h0));
        chk(32'h1, 1'h0, .v4(1'h0));
        chk(32'h1, 1'h1, .pr(8'hff), .tt(8'h0), .mf(1'h1), .op(1'h1), .s(32'h0), .d(32'h0));
        chk(32'h0006_0003, 1'h1);
        chk(32'h0006_0003, 1'h0, .pr(8'h07));
        chk(32'h00ff_0003, 1'h1, .pr(8'hff));
        chk(32'h5, 1'h1, .pr(8'h01));
        cmp_word({29'h0, sub_enable_q}, 32'h4);
        chk(32'h5, 1'h0);
        chk(32'h7, 1'h1, .pr(8'h11));
        cmp_word({29'h0, sub_enable_q}, 32'h2);
        chk(32'h7, 1'h0);
        chk(32'h9, 1'h1);
        cmp_word({29'h0, sub_enable_q}, 32'h1);
        chk(32'h9, 1'h0, .pr(8'h11));
        chk(32'h11, 1'h0);
        chk(32'h11, 1'h1, .tt(8'h0));
        chk(32'h21, 1'h1, .tt(8'hff));
        chk(32'h41, 1'h0, .mf(1'h1));
        chk(32'h41, 1'h0, .of(13'h1));
        chk(32'h41, 1'h1);
        chk(32'h81, 1'h1, .of(13'h1fff));
        chk(32'h101, 1'h0, .op(1'h1));
        chk(32'h201, 1'h1, .op(1'h1));
        chk(32'h401, 1'h1);
        chk(32'h401, 1'h0, .s(32'h0a00_0000));
        chk(32'h801, 1'h1, .s(32'h0a00_00fe));
        chk(32'h801, 1'h0, .s(32'h0a00_0101));
        chk(32'h1001, 1'h0, .d(32'hc0a8_0100));
        chk(32'h2001, 1'h1, .d(32'hc0a8_ffff));
        chk(32'h2001, 1'h0, .d(32'hc0a9_0101));
        chk(32'h0006_1443, 1'h1);
        chk(32'h0006_1443, 1'h0, .mf(1'h1));
        chk(32'h21, 1'h0, .tt(8'h0));
        chk(32'h0f, 1'h0);
        chk(32'hc01, 1'h0);
        bus(1'h0, status_offset, 32'h0);
        cmp_word(rd, 32'h0010_0002);
        reset <= 1'h1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'h0;
        @(posedge clk_sys);
        bus(1'h0, control_offset, 32'h0);
        cmp_word(rd, control_reset);
        bus(1'h0, status_offset, 32'h0);
        cmp_word(rd, 32'h0);
        final_report();
    end
endmodule // testbench
